// ### src/rtc_backup_domain.sv
// Backup-domain real-time counter with prescaler, alarm and storage.
// Operation
// - Ten 16-bit backup words kept without main supply.
// - Run from backup supply when main absent.
// - Counters run continuously without software.
// - Separate alarm and periodic interrupt requests.
// - Clock source: LSE, LSI or HSE/128.
// - Drive 512 Hz calibration output pin.
// - 32-bit software-loadable main counter.
// - Alarm when counter reaches compare value.
// - 20-bit prescaler, default one tick per second.
`timescale 1ns/1ps
`include "rtc_consts.svh"
module rtc_backup_domain (
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic                      main_supply_ok,
  input  wire logic                      backup_supply_pin_ok,
  input  wire rtc_pkg::clk_src_t         clk_src,
  input  wire logic                      lse_in,
  input  wire logic                      lsi_in,
  input  wire logic                      hse_in,
  input  wire logic                      presc_load,
  input  wire logic [`RTC_PRESC_W-1:0]   presc_reload,
  input  wire logic                      cnt_load,
  input  wire logic [`RTC_CNT_W-1:0]     cnt_value,
  input  wire logic                      cmp_load,
  input  wire logic [`RTC_CNT_W-1:0]     cmp_value,
  input  wire logic                      sec_irq_en,
  input  wire logic                      alarm_irq_en,
  input  wire logic                      sec_clear,
  input  wire logic                      alarm_clear,
  input  wire logic                      cal_out_en,
  input  wire logic                      bkp_wr,
  input  wire logic [`RTC_BKP_IDX_W-1:0] bkp_addr,
  input  wire logic [`RTC_BKP_W-1:0]     bkp_wdata,
  output logic [`RTC_BKP_W-1:0]          bkp_rdata,
  output logic [`RTC_CNT_W-1:0]          cnt_q,
  output logic                           sec_flag_q,
  output logic                           alarm_flag_q,
  output logic                           sec_irq,
  output logic                           alarm_irq,
  output logic                           cal_out_q,
  output logic                           powered
);
  import rtc_pkg::*;

  logic [`RTC_SYNC_W-1:0]   lse_s_q;
  logic [`RTC_SYNC_W-1:0]   lsi_s_q;
  logic [`RTC_SYNC_W-1:0]   hse_s_q;
  logic                     lse_st_q;
  logic                     lsi_st_q;
  logic                     hse_st_q;
  logic                     lse_rise;
  logic                     lsi_rise;
  logic                     hse_rise;
  logic [6:0]               hse_div_q;
  logic                     hse_tick;
  logic                     src_tick;
  logic [`RTC_PRESC_W-1:0]  reload_q;
  logic [`RTC_PRESC_W-1:0]  presc_q;
  logic                     tc_tick;
  logic [`RTC_CNT_W-1:0]    cmp_q;
  logic [4:0]               cal_div_q;
  logic                     alarm_hit;

  // -----------------------------------------------------------------
  // Power switch.
  // -----------------------------------------------------------------
  assign powered = main_supply_ok | backup_supply_pin_ok;

  // -----------------------------------------------------------------
  // Clock source synchronisers and selection.
  // -----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lse_s_q <= '0;
      lsi_s_q <= '0;
      hse_s_q <= '0;
    end else begin
      lse_s_q <= {lse_s_q[1:0], lse_in};
      lsi_s_q <= {lsi_s_q[1:0], lsi_in};
      hse_s_q <= {hse_s_q[1:0], hse_in};
    end
  end

  // A change counts once the second and third stages agree.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lse_st_q <= 1'b0;
      lsi_st_q <= 1'b0;
      hse_st_q <= 1'b0;
    end else begin
      if (lse_s_q[1] == lse_s_q[2]) lse_st_q <= lse_s_q[2];
      if (lsi_s_q[1] == lsi_s_q[2]) lsi_st_q <= lsi_s_q[2];
      if (hse_s_q[1] == hse_s_q[2]) hse_st_q <= hse_s_q[2];
    end
  end

  assign lse_rise = (lse_s_q[1] == lse_s_q[2]) && lse_s_q[2] && !lse_st_q;
  assign lsi_rise = (lsi_s_q[1] == lsi_s_q[2]) && lsi_s_q[2] && !lsi_st_q;
  assign hse_rise = (hse_s_q[1] == hse_s_q[2]) && hse_s_q[2] && !hse_st_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hse_div_q <= '0;
    end else if (hse_rise) begin
      hse_div_q <= (hse_div_q == 7'(`RTC_HSE_DIV)) ? '0 : hse_div_q + 7'h01;
    end
  end

  assign hse_tick = hse_rise && (hse_div_q == 7'(`RTC_HSE_DIV));

  always_comb begin
    case (clk_src)
      SRC_LSE:     src_tick = lse_rise;
      SRC_LSI:     src_tick = lsi_rise;
      SRC_HSE_DIV: src_tick = hse_tick;
      default:     src_tick = 1'b0;
    endcase
  end

  // -----------------------------------------------------------------
  // Prescaler.
  // -----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reload_q <= `RTC_PRESC_RST;
    end else if (presc_load) begin
      reload_q <= presc_reload;
    end
  end

  assign tc_tick = src_tick && (presc_q == '0) && powered;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      presc_q <= `RTC_PRESC_RST;
    end else if (presc_load) begin
      presc_q <= presc_reload;
    end else if (src_tick && powered) begin
      presc_q <= (presc_q == '0) ? reload_q : presc_q - `RTC_PRESC_W'(1);
    end
  end

  // -----------------------------------------------------------------
  // Main counter and alarm.
  // -----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (cnt_load) begin
      cnt_q <= cnt_value;
    end else if (tc_tick) begin
      cnt_q <= cnt_q + `RTC_CNT_W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmp_q <= '1;
    end else if (cmp_load) begin
      cmp_q <= cmp_value;
    end
  end

  assign alarm_hit = tc_tick && !cnt_load && ((cnt_q + `RTC_CNT_W'(1)) == cmp_q);

  // Set wins over a clear in the same cycle.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_flag_q <= 1'b0;
    end else if (alarm_hit) begin
      alarm_flag_q <= 1'b1;
    end else if (alarm_clear) begin
      alarm_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sec_flag_q <= 1'b0;
    end else if (tc_tick) begin
      sec_flag_q <= 1'b1;
    end else if (sec_clear) begin
      sec_flag_q <= 1'b0;
    end
  end

  assign sec_irq   = sec_flag_q & sec_irq_en;
  assign alarm_irq = alarm_flag_q & alarm_irq_en;

  // -----------------------------------------------------------------
  // Calibration output: toggles every 32 source rises, a 64-rise period.
  // -----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cal_div_q <= '0;
      cal_out_q <= 1'b0;
    end else if (!cal_out_en) begin
      cal_div_q <= '0;
      cal_out_q <= 1'b0;
    end else if (src_tick) begin
      cal_div_q <= cal_div_q + 5'h01;
      if (cal_div_q == `RTC_CAL_DIV) cal_out_q <= ~cal_out_q;
    end
  end

  // -----------------------------------------------------------------
  // Backup storage.
  // -----------------------------------------------------------------
  bkp_if bkp ();

  assign bkp.wr_en = bkp_wr && powered;
  assign bkp.addr  = bkp_addr;
  assign bkp.wdata = bkp_wdata;
  assign bkp_rdata = bkp.rdata;

  bkp_mem u_mem (
    .clk   (clk),
    .rst_n (rst_n),
    .bus   (bkp.mem)
  );

  // -----------------------------------------------------------------
  // Checks.
  // -----------------------------------------------------------------
  a_cnt_tick_inc: assert property (@(posedge clk) disable iff (!rst_n)
    tc_tick && !cnt_load |=> cnt_q == $past(cnt_q) + `RTC_CNT_W'(1))
    else $error("Counter did not advance on tick.");
  a_cnt_load_val: assert property (@(posedge clk) disable iff (!rst_n)
    cnt_load |=> cnt_q == $past(cnt_value))
    else $error("Counter load lost.");
  a_cnt_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !tc_tick && !cnt_load |=> $stable(cnt_q))
    else $error("Counter moved without tick.");
  a_alarm_set: assert property (@(posedge clk) disable iff (!rst_n)
    alarm_hit |=> alarm_flag_q && cnt_q == $past(cmp_q))
    else $error("Alarm not raised at match.");
  a_sec_sticky: assert property (@(posedge clk) disable iff (!rst_n)
    sec_flag_q && !sec_clear |=> sec_flag_q)
    else $error("Periodic flag dropped without clear.");
  a_sec_set: assert property (@(posedge clk) disable iff (!rst_n)
    tc_tick ##1 sec_irq_en |-> sec_irq)
    else $error("Periodic request missing.");
  a_presc_wrap: assert property (@(posedge clk) disable iff (!rst_n)
    tc_tick && !presc_load |=> presc_q == reload_q)
    else $error("Prescaler did not reload.");
  a_hse_div: assert property (@(posedge clk) disable iff (!rst_n)
    hse_tick |=> hse_div_q == 7'h00)
    else $error("High-speed divider wrap wrong.");
  a_bkp_gate: assert property (@(posedge clk) disable iff (!rst_n)
    !powered |-> !bkp.wr_en)
    else $error("Backup write without supply.");
endmodule

// ### src/rtc_consts.svh
// Constants for the backup-domain real-time counter block.
`ifndef RTC_CONSTS_SVH
`define RTC_CONSTS_SVH
`define RTC_PRESC_W      20
`define RTC_PRESC_RST    20'h07FFF
`define RTC_CNT_W        32
`define RTC_BKP_N        10
`define RTC_BKP_IDX_W    4
`define RTC_BKP_W        16
`define RTC_HSE_DIV      8'h7F
`define RTC_CAL_DIV      5'h1F
`define RTC_SYNC_W       3
`endif

// ### src/rtc_pkg.sv
// Types shared by the real-time counter block.
package rtc_pkg;
  typedef enum logic [1:0] {
    SRC_LSE,
    SRC_LSI,
    SRC_HSE_DIV
  } clk_src_t;
endpackage

// ### src/bkp_if.sv
// Interface between the counter block and its backup storage.
`timescale 1ns/1ps
`include "rtc_consts.svh"
interface bkp_if;
  logic                      wr_en;
  logic [`RTC_BKP_IDX_W-1:0] addr;
  logic [`RTC_BKP_W-1:0]     wdata;
  logic [`RTC_BKP_W-1:0]     rdata;
  modport ctrl (output wr_en, output addr, output wdata, input rdata);
  modport mem  (input wr_en, input addr, input wdata, output rdata);
endinterface

// ### src/bkp_mem.sv
// Ten-word backup storage with registered read data.
`timescale 1ns/1ps
`include "rtc_consts.svh"
module bkp_mem (
  input wire logic clk,
  input wire logic rst_n,
  bkp_if.mem       bus
);
  logic [`RTC_BKP_W-1:0] mem_q [`RTC_BKP_N];

  // -----------------------------------------------------------------
  // Storage.
  // -----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `RTC_BKP_N; i++) begin
        mem_q[i] <= '0;
      end
    end else if (bus.wr_en && bus.addr < `RTC_BKP_IDX_W'(`RTC_BKP_N)) begin
      mem_q[bus.addr] <= bus.wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus.rdata <= '0;
    end else if (bus.addr < `RTC_BKP_IDX_W'(`RTC_BKP_N)) begin
      bus.rdata <= mem_q[bus.addr];
    end else begin
      bus.rdata <= '0;
    end
  end
endmodule

// ### testbench/test_rtc_backup_domain.sv
// Self-checking bench for the backup-domain real-time counter block.
`timescale 1ns/1ps
`include "rtc_consts.svh"
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin miscompares++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); end end
module test_rtc_backup_domain;
  import rtc_pkg::*;
  logic clk, rst_n, main_supply_ok, backup_supply_pin_ok, lse_in, lsi_in, hse_in;
  logic presc_load, cnt_load, cmp_load, sec_irq_en, alarm_irq_en, sec_clear, alarm_clear;
  logic cal_out_en, bkp_wr, sec_flag_q, alarm_flag_q, sec_irq, alarm_irq, cal_out_q, powered;
  clk_src_t clk_src;
  logic [`RTC_PRESC_W-1:0] presc_reload;
  logic [`RTC_CNT_W-1:0] cnt_value, cmp_value, cnt_q, c;
  logic [`RTC_BKP_IDX_W-1:0] bkp_addr;
  logic [`RTC_BKP_W-1:0] bkp_wdata, bkp_rdata;
  logic [`RTC_BKP_W-1:0] mem_exp [0:9];
  int miscompares, comparisons, cycles, seed, r, lse_total;
  localparam logic [5:0] st_presc = 6'h20, st_cnt = 6'h10, st_cmp = 6'h08;
  localparam logic [5:0] st_wr = 6'h04, st_sclr = 6'h02, st_aclr = 6'h01;
  rtc_backup_domain dut (.clk(clk), .rst_n(rst_n), .main_supply_ok(main_supply_ok),
    .backup_supply_pin_ok(backup_supply_pin_ok), .clk_src(clk_src), .lse_in(lse_in),
    .lsi_in(lsi_in), .hse_in(hse_in), .presc_load(presc_load), .presc_reload(presc_reload),
    .cnt_load(cnt_load), .cnt_value(cnt_value), .cmp_load(cmp_load), .cmp_value(cmp_value),
    .sec_irq_en(sec_irq_en), .alarm_irq_en(alarm_irq_en), .sec_clear(sec_clear),
    .alarm_clear(alarm_clear), .cal_out_en(cal_out_en), .bkp_wr(bkp_wr), .bkp_addr(bkp_addr),
    .bkp_wdata(bkp_wdata), .bkp_rdata(bkp_rdata), .cnt_q(cnt_q), .sec_flag_q(sec_flag_q),
    .alarm_flag_q(alarm_flag_q), .sec_irq(sec_irq), .alarm_irq(alarm_irq),
    .cal_out_q(cal_out_q), .powered(powered));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      give_verdict();
    end
  end
  function automatic logic cal_lvl(input int n);
    return n[5];
  endfunction
  task automatic give_verdict();
    if (miscompares == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic strobe(input logic [5:0] w);
    @(negedge clk);
    {presc_load, cnt_load, cmp_load, bkp_wr, sec_clear, alarm_clear} = w;
    @(negedge clk);
    {presc_load, cnt_load, cmp_load, bkp_wr, sec_clear, alarm_clear} = 6'h00;
  endtask
  task automatic pulse(input clk_src_t s, input int n);
    repeat (n) begin
      @(negedge clk);
      case (s) SRC_LSE: lse_in = 1'b1; SRC_LSI: lsi_in = 1'b1; default: hse_in = 1'b1; endcase
      repeat (8) @(negedge clk);
      {lse_in, lsi_in, hse_in} = 3'b000;
      repeat (8) @(negedge clk);
    end
  endtask
  task automatic load(input int rl, input logic [`RTC_CNT_W-1:0] v);
    presc_reload = rl[`RTC_PRESC_W-1:0];
    cnt_value = v;
    strobe(st_presc);
    strobe(st_cnt);
  endtask
  initial begin
    seed = 32'hc972dcf6;
    {lse_in, lsi_in, hse_in, presc_load, cnt_load, cmp_load, sec_clear, alarm_clear, bkp_wr} = '0;
    {sec_irq_en, alarm_irq_en, presc_reload, cnt_value, cmp_value, bkp_addr, bkp_wdata} = '0;
    {main_supply_ok, backup_supply_pin_ok, cal_out_en} = 3'b111;
    clk_src = SRC_LSE;
    rst_n = 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    `CHK("cnt_q", 32'h0, cnt_q)
    `CHK("flags", 4'h0, {sec_flag_q, alarm_flag_q, sec_irq, alarm_irq})
    `CHK("cal_out_q", 1'b0, cal_out_q)
    for (int i = 0; i < 4; i++) begin
      {main_supply_ok, backup_supply_pin_ok} = i[1:0];
      #1;
      `CHK("powered", (i != 0), powered)
    end
    for (int i = 0; i < 11; i++) begin
      bkp_addr = i[3:0];
      bkp_wdata = $random(seed);
      if (i < 10) mem_exp[i] = bkp_wdata;
      strobe(st_wr);
    end
    for (int i = 0; i < 11; i++) begin
      bkp_addr = i[3:0];
      repeat (2) @(negedge clk);
      `CHK("bkp_rdata", (i < 10) ? mem_exp[i] : 16'h0000, bkp_rdata)
    end
    for (int k = 0; k < 4; k++) begin
      r = (k == 0) ? 0 : ($random(seed) & 7);
      c = (k == 0) ? 32'hFFFFFFFE : $random(seed);
      cmp_value = c + 2;
      if (k != 0) strobe(st_cmp);
      load(r, c);
      sec_irq_en = $random(seed);
      pulse(SRC_LSE, r + 1);
      lse_total += r + 1;
      `CHK("cnt_q", c + 1, cnt_q)
      `CHK("alarm_flag_q", (k == 0), alarm_flag_q)
      `CHK("sec_flag_q", 1'b1, sec_flag_q)
      `CHK("sec_irq", sec_irq_en, sec_irq)
      strobe(st_sclr);
      `CHK("sec_flag_q", 1'b0, sec_flag_q)
      pulse(SRC_LSE, r + 1);
      lse_total += r + 1;
      alarm_irq_en = 1'b1;
      #1;
      `CHK("cnt_q", c + 2, cnt_q)
      `CHK("alarm_irq", 1'b1, alarm_irq)
      strobe(st_aclr);
      `CHK("alarm_flag_q", 1'b0, alarm_flag_q)
      alarm_irq_en = 1'b0;
    end
    `CHK("cal_out_q", cal_lvl(lse_total), cal_out_q)
    pulse(SRC_LSE, 96 - lse_total);
    `CHK("cal_out_q", cal_lvl(96), cal_out_q)
    cal_out_en = 1'b0;
    @(negedge clk);
    `CHK("cal_out_q", 1'b0, cal_out_q)
    for (int s = 0; s < 3; s++) begin
      clk_src = clk_src_t'(s);
      c = $random(seed);
      load(0, c);
      pulse((s == 0) ? SRC_LSI : SRC_LSE, 2);
      `CHK("cnt_q", c, cnt_q)
      pulse(clk_src, (s == 2) ? 128 : 1);
      `CHK("cnt_q", c + 1, cnt_q)
    end
    clk_src = SRC_LSE;
    load(0, c);
    {main_supply_ok, backup_supply_pin_ok} = 2'b01;
    pulse(SRC_LSE, 2);
    `CHK("cnt_q", c + 2, cnt_q)
    {main_supply_ok, backup_supply_pin_ok} = 2'b00;
    pulse(SRC_LSE, 2);
    `CHK("cnt_q", c + 2, cnt_q)
    bkp_addr = 4'h0;
    bkp_wdata = ~mem_exp[0];
    strobe(st_wr);
    {main_supply_ok, backup_supply_pin_ok} = 2'b01;
    repeat (2) @(negedge clk);
    `CHK("bkp_rdata", mem_exp[0], bkp_rdata)
    give_verdict();
  end
endmodule
